//--- hw/arcf_pkg.sv
/*
  Constants, field layouts and helpers for the action request controller.
  Assumes a 32-bit byte-addressed, word-aligned shared memory and 32-bit software bus.
*/
package arcf_pkg;

  // ==========================================================
  // Software register map (byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SELECT = 8'h04;
  localparam logic [7:0] REG_ACTION = 8'h08;
  localparam logic [7:0] REG_QSTART = 8'h0c;
  localparam logic [7:0] REG_QLEN = 8'h10;
  localparam logic [7:0] REG_CFG_BASE = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_LAST_IRQ = 8'h1c;
  localparam int CTRL_GO_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_REFUSED_BIT = 3;
  localparam int ST_OUTST_BIT = 4;
  localparam int ST_MFL_UNSET_BIT = 5;

  // ==========================================================
  // Action command word fields
  localparam int ACT_PCM_LSB = 29;
  localparam int ACT_PCM_W = 3;
  localparam int ACT_MFL_LSB = 16;
  localparam int ACT_MFL_W = 13;
  localparam int ACT_INIT_ALL = 15;
  localparam int ACT_INIT_CH = 14;
  localparam int ACT_CHAN_LSB = 8;
  localparam int ACT_CHAN_W = 5;
  localparam int ACT_ACK_MASK = 7;
  localparam int ACT_FULL_REINIT = 6;
  localparam int ACT_LOOP_CH = 5;
  localparam int ACT_LOOP_EXT = 4;
  localparam int ACT_LOOP_INT = 3;
  localparam int ACT_NEW_QUEUE = 2;

  typedef enum logic [2:0] {
    PCM_T1_1536 = 3'h0,
    PCM_T1_1544 = 3'h4,
    PCM_CEPT = 3'h5,
    PCM_4M_EVEN = 3'h6,
    PCM_4M_ODD = 3'h7
  } pcm_format_type;

  // ==========================================================
  // Configuration section layout, sizes in long words, offsets in bytes
  localparam int CS_ACTION_N = 1;
  localparam int CS_QSPEC_N = 2;
  localparam int CS_TSLOT_N = 32;
  localparam int CS_CHSPEC_N = 128;
  localparam int CS_CDA_N = 64;
  localparam logic [31:0] CS_ACTION_OFS = 32'h0;
  localparam logic [31:0] CS_QSTART_OFS = 32'h4;
  localparam logic [31:0] CS_QLEN_OFS = 32'h8;
  localparam int CS_TOTAL_N =
    CS_ACTION_N + CS_QSPEC_N + CS_TSLOT_N + CS_CHSPEC_N + CS_CDA_N;

  // ==========================================================
  // Interrupt words and queue limits
  localparam int IRQ_DONE_BIT = 15;
  localparam int IRQ_FAIL_BIT = 14;
  localparam int QLEN_W = 13;
  localparam logic [QLEN_W-1:0] QLEN_MIN = 13'h0010;
  localparam logic [QLEN_W-1:0] QLEN_MAX = 13'h1000;
  localparam int SEL_W = 5;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // Fixed location of the control start address for a select pattern.
  function automatic logic [31:0] ctrl_location(
    input logic [SEL_W-1:0] sel);
    return {{10{sel[4]}}, {6{sel[3]}}, {12{sel[2]}}, sel[1], sel[0],
            WORD_ALIGN};
  endfunction

  // At most one of the three initialise bits.
  function automatic logic init_ok(input logic [31:0] a);
    return !((a[ACT_INIT_ALL] && a[ACT_INIT_CH]) ||
             (a[ACT_INIT_ALL] && a[ACT_FULL_REINIT]) ||
             (a[ACT_INIT_CH] && a[ACT_FULL_REINIT]));
  endfunction

  // Loop selection other than the two forbidden patterns.
  function automatic logic loop_ok(input logic [31:0] a);
    return !(a[ACT_LOOP_CH] && (a[ACT_LOOP_EXT] == a[ACT_LOOP_INT]));
  endfunction

  function automatic logic pcm_ok(input logic [31:0] a);
    logic [ACT_PCM_W-1:0] p;
    p = a[ACT_PCM_LSB +: ACT_PCM_W];
    return p == PCM_T1_1536 || p == PCM_T1_1544 || p == PCM_CEPT ||
           p == PCM_4M_EVEN || p == PCM_4M_ODD;
  endfunction

endpackage

//--- hw/xfer_if.sv
/*
  Word transfer carrier between the sequencer and the memory port.
  Assumes one clock; start is a one-cycle pulse, done answers it.
*/
`timescale 1ns/10ps
interface xfer_if;
  logic start;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic done;
  modport requester(output start, output we, output addr,
                    output wdata, input rdata, input done);
  modport server(input start, input we, input addr, input wdata,
                 output rdata, output done);
endinterface

//--- hw/mem_port.sv
/*
  Shared memory master: one 32-bit word per request, held until ack.
  Assumes the memory answers with a one-cycle mem_ack.
*/
`timescale 1ns/10ps
module mem_port (
  input wire logic core_clk,
  input wire logic reset,
  xfer_if.server xf,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  import arcf_pkg::*;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
  } port_state_type;

  port_state_type s_q, s_d;

  // ==========================================================
  // Request holding.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.req && xf.start) begin
      s_d.req = 1'b1;
      s_d.we = xf.we;
      s_d.addr = {xf.addr[31:2], WORD_ALIGN};
      s_d.wdata = xf.wdata;
    end else if (s_q.req && mem_ack) begin
      s_d.req = 1'b0;
      s_d.rdata = mem_rdata;
      s_d.done = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_req = s_q.req;
  assign mem_we = s_q.we;
  assign mem_addr = s_q.addr;
  assign mem_wdata = s_q.wdata;
  assign xf.rdata = s_q.rdata;
  assign xf.done = s_q.done;

  // ==========================================================
  // Checks.
  AST_ALIGN: assert property (@(posedge core_clk) disable iff (reset)
    mem_req |-> mem_addr[1:0] == WORD_ALIGN)
    else $error("memory address not word aligned");

  AST_MEM_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before ack");
endmodule

//--- hw/strobe_gen.sv
/*
  Active-low action request strobe of a fixed width.
  Assumes start is a one-cycle pulse given only while not busy.
*/
`timescale 1ns/10ps
module strobe_gen #(
  parameter int LOW_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  output logic strobe_n,
  output logic busy
);
  localparam int CW = $clog2(LOW_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(LOW_CYCLES - 1);

  generate
    if (LOW_CYCLES < 1) begin : g_bad
      $error("LOW_CYCLES must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic strobe_n;
    logic [CW-1:0] cnt;
  } strobe_state_type;

  strobe_state_type s_q, s_d;

  // ==========================================================
  // Pulse timing.
  always_comb begin
    s_d = s_q;
    if (s_q.strobe_n) begin
      if (start) begin
        s_d.strobe_n = 1'b0;
        s_d.cnt = '0;
      end
    end else if (s_q.cnt == LAST) begin
      s_d.strobe_n = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '{strobe_n: 1'b1, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign strobe_n = s_q.strobe_n;
  assign busy = !s_q.strobe_n;

  AST_PULSE_LEN: assert property (@(posedge core_clk) disable iff (reset)
    !strobe_n |-> s_q.cnt <= LAST)
    else $error("action strobe held too long");
endmodule

//--- hw/action_request_config_fetch.sv
/*
  Host-side controller for the action request and configuration fetch.
  Writes the control start address, action word and queue specification
  into shared memory, strobes the action request and follows the cyclic
  interrupt queue. Assumes the device behind the pins keeps its own side.
*/
// The address map and the Wishbone slave port were chosen for this implementation.
// Overview of operation
// - All shared memory structures sit on long-word boundaries.
// - Config section: action, two queue words, 32, 128, 64 words.
// - Length check skipped in two modes; host loads sensible maximum.
// - Host switches off channels of reinitialised slots beforehand.
// - Host sets at most one initialise bit per action word.
// - Complete external loop mirrors input; timing must match.
// - Complete internal loop feeds output back; timing must match.
// - Channelwise external loop returns one channel to transmit.
// - Channelwise internal loop returns one channel to receive.
// - Close loop: no initialise bits, loop bits, fields unchanged.
// - Open loop: no initialise bits, pattern 011, same channel.
// - Queue length lies between 16 and 4096 long words.
// - No new request before acknowledge or failure interrupt.
`timescale 1ns/10ps
module action_request_config_fetch #(
  parameter int STROBE_CYCLES = 4,
  parameter int PEND_W = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  output logic [arcf_pkg::SEL_W-1:0] ctrl_location_select,
  output logic action_request_strobe_n,
  input wire logic dev_irq,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  import arcf_pkg::*;

  generate
    if (PEND_W < 1 || STROBE_CYCLES < 1) begin : g_bad
      $error("PEND_W and STROBE_CYCLES must be at least one");
    end
  endgenerate

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WR_LOC = 7'h02,
    ST_WR_ACT = 7'h04,
    ST_WR_QSTART = 7'h08,
    ST_WR_QLEN = 7'h10,
    ST_WAIT = 7'h20,
    ST_RD_IRQ = 7'h40
  } ctl_state_type;

  typedef struct packed {
    ctl_state_type st;
    logic ack;
    logic [31:0] rdat;
    logic [SEL_W-1:0] sel;
    logic [31:0] act;
    logic [31:0] qstart;
    logic [31:0] qlen;
    logic [31:0] cfg_base;
    logic [31:0] last_irq;
    logic busy;
    logic done;
    logic fail;
    logic refused;
    logic outstanding;
    logic [QLEN_W-1:0] ptr;
    logic [QLEN_W-1:0] cur_qlen;
    logic [31:0] cur_qstart;
    logic [PEND_W-1:0] pending;
    logic xs;
    logic xwe;
    logic [31:0] xaddr;
    logic [31:0] xwdata;
    logic pstart;
  } top_state_type;

  top_state_type s_q, s_d;
  logic strobe_busy;
  xfer_if xf();

  assign xf.start = s_q.xs;
  assign xf.we = s_q.xwe;
  assign xf.addr = s_q.xaddr;
  assign xf.wdata = s_q.xwdata;

  // ==========================================================
  // Submodules.
  mem_port u_mem (
    .core_clk(core_clk),
    .reset(reset),
    .xf(xf.server),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  strobe_gen #(
    .LOW_CYCLES(STROBE_CYCLES)
  ) u_strobe (
    .core_clk(core_clk),
    .reset(reset),
    .start(s_q.pstart),
    .strobe_n(action_request_strobe_n),
    .busy(strobe_busy)
  );

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
    input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wr[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Request checks and sequencing.
  logic new_access;
  logic go;
  logic go_ok;
  logic req_ok;
  logic qlen_ok;
  logic [QLEN_W-1:0] qlen_field;
  logic [QLEN_W-1:0] ptr_inc;
  logic pend_inc;
  logic pend_dec;
  logic [31:0] q_addr;

  assign qlen_field = s_q.qlen[QLEN_W-1:0];
  assign qlen_ok = qlen_field >= QLEN_MIN && qlen_field <= QLEN_MAX
    && s_q.qlen[31:QLEN_W] == '0;
  assign ptr_inc = s_q.ptr + QLEN_W'(1);
  assign q_addr = s_q.cur_qstart + {17'h0, s_q.ptr, WORD_ALIGN};

  // Refuse words whose meaning is undefined or memory that is misaligned.
  assign req_ok = init_ok(s_q.act)
    && loop_ok(s_q.act)
    && pcm_ok(s_q.act)
    && s_q.cfg_base[1:0] == WORD_ALIGN
    && (!s_q.act[ACT_NEW_QUEUE] ||
        (qlen_ok && s_q.qstart[1:0] == WORD_ALIGN));

  always_comb begin
    s_d = s_q;
    new_access = wb_cyc && wb_stb && !s_q.ack;
    go = 1'b0;
    pend_dec = 1'b0;
    pend_inc = dev_irq;
    s_d.ack = new_access;
    s_d.rdat = '0;
    s_d.xs = 1'b0;
    s_d.pstart = 1'b0;
    if (new_access && !wb_we) begin
      case (wb_adr)
        REG_SELECT: s_d.rdat = {27'h0, s_q.sel};
        REG_ACTION: s_d.rdat = s_q.act;
        REG_QSTART: s_d.rdat = s_q.qstart;
        REG_QLEN: s_d.rdat = s_q.qlen;
        REG_CFG_BASE: s_d.rdat = s_q.cfg_base;
        REG_STATUS: begin
          s_d.rdat[ST_BUSY_BIT] = s_q.busy;
          s_d.rdat[ST_DONE_BIT] = s_q.done;
          s_d.rdat[ST_FAIL_BIT] = s_q.fail;
          s_d.rdat[ST_REFUSED_BIT] = s_q.refused;
          s_d.rdat[ST_OUTST_BIT] = s_q.outstanding;
          // Zero maximum length aborts every checked frame.
          s_d.rdat[ST_MFL_UNSET_BIT] =
            s_q.act[ACT_MFL_LSB +: ACT_MFL_W] == '0;
        end
        REG_LAST_IRQ: s_d.rdat = s_q.last_irq;
        default: s_d.rdat = '0;
      endcase
    end
    if (new_access && wb_we) begin
      case (wb_adr)
        REG_CTRL: go = wb_sel[0] && wb_dat_i[CTRL_GO_BIT];
        REG_STATUS: begin
          if (wb_sel[0]) begin
            s_d.done = s_q.done && !wb_dat_i[ST_DONE_BIT];
            s_d.fail = s_q.fail && !wb_dat_i[ST_FAIL_BIT];
            s_d.refused = s_q.refused && !wb_dat_i[ST_REFUSED_BIT];
          end
        end
        default: begin
          // Setup words are frozen while a request is in flight.
          if (s_q.busy) begin
            s_d.refused = 1'b1;
          end else begin
            case (wb_adr)
              // Select changes reach the device at its next strobe.
              REG_SELECT: begin
                if (wb_sel[0]) begin
                  s_d.sel = wb_dat_i[SEL_W-1:0];
                end
              end
              REG_ACTION: s_d.act = merge_bytes(s_q.act, wb_dat_i, wb_sel);
              REG_QSTART:
                s_d.qstart = merge_bytes(s_q.qstart, wb_dat_i, wb_sel);
              REG_QLEN: s_d.qlen = merge_bytes(s_q.qlen, wb_dat_i, wb_sel);
              REG_CFG_BASE:
                s_d.cfg_base = merge_bytes(s_q.cfg_base, wb_dat_i, wb_sel);
              default: s_d.refused = s_q.refused;
            endcase
          end
        end
      endcase
    end
    // A request is only issued once the previous one and any queue read end.
    go_ok = go && !s_q.busy && s_q.st == ST_IDLE && req_ok;
    if (go && !go_ok) begin
      s_d.refused = 1'b1;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (go_ok) begin
          s_d.busy = 1'b1;
          s_d.xs = 1'b1;
          s_d.xwe = 1'b1;
          s_d.xaddr = ctrl_location(s_q.sel);
          s_d.xwdata = s_q.cfg_base;
          s_d.st = ST_WR_LOC;
        end else if (s_q.pending != '0) begin
          pend_dec = 1'b1;
          s_d.xs = 1'b1;
          s_d.xwe = 1'b0;
          s_d.xaddr = q_addr;
          s_d.st = ST_RD_IRQ;
        end
      end
      ST_WR_LOC: begin
        if (xf.done) begin
          // The mode, loop and initialise fields travel as written.
          s_d.xs = 1'b1;
          s_d.xaddr = s_q.cfg_base + CS_ACTION_OFS;
          s_d.xwdata = s_q.act;
          s_d.st = ST_WR_ACT;
        end
      end
      ST_WR_ACT: begin
        if (xf.done) begin
          if (s_q.act[ACT_NEW_QUEUE]) begin
            s_d.xs = 1'b1;
            s_d.xaddr = s_q.cfg_base + CS_QSTART_OFS;
            s_d.xwdata = s_q.qstart;
            s_d.st = ST_WR_QSTART;
          end else begin
            s_d.pstart = 1'b1;
            s_d.outstanding = !s_q.act[ACT_ACK_MASK];
            s_d.done = s_d.done || s_q.act[ACT_ACK_MASK];
            s_d.st = ST_WAIT;
          end
        end
      end
      ST_WR_QSTART: begin
        if (xf.done) begin
          s_d.xs = 1'b1;
          s_d.xaddr = s_q.cfg_base + CS_QLEN_OFS;
          s_d.xwdata = s_q.qlen;
          s_d.st = ST_WR_QLEN;
        end
      end
      ST_WR_QLEN: begin
        if (xf.done) begin
          // Later interrupt words arrive in the new queue from its start.
          s_d.cur_qstart = s_q.qstart;
          s_d.cur_qlen = qlen_field;
          s_d.ptr = '0;
          s_d.pending = '0;
          s_d.pstart = 1'b1;
          s_d.outstanding = !s_q.act[ACT_ACK_MASK];
          s_d.done = s_d.done || s_q.act[ACT_ACK_MASK];
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (s_q.pending != '0) begin
          pend_dec = 1'b1;
          s_d.xs = 1'b1;
          s_d.xwe = 1'b0;
          s_d.xaddr = q_addr;
          s_d.st = ST_RD_IRQ;
        end else if (!s_q.outstanding && !strobe_busy && !s_q.pstart) begin
          s_d.busy = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      ST_RD_IRQ: begin
        if (xf.done) begin
          s_d.last_irq = xf.rdata;
          s_d.ptr = (ptr_inc == s_q.cur_qlen) ? '0 : ptr_inc;
          if (s_q.outstanding && xf.rdata[IRQ_DONE_BIT]) begin
            s_d.done = 1'b1;
            s_d.outstanding = 1'b0;
          end
          if (s_q.outstanding && xf.rdata[IRQ_FAIL_BIT]) begin
            s_d.fail = 1'b1;
            s_d.outstanding = 1'b0;
          end
          s_d.st = s_q.busy ? ST_WAIT : ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // One pending read per interrupt pulse until the count saturates at all ones; never lose a coincident pulse.
    if (s_q.st == ST_WR_QLEN && xf.done) begin
      s_d.pending = {{(PEND_W-1){1'b0}}, pend_inc};
    end else if (pend_inc && !pend_dec) begin
      if (s_q.pending != '1) begin
        s_d.pending = s_q.pending + PEND_W'(1);
      end
    end else if (pend_dec && !pend_inc) begin
      s_d.pending = s_q.pending - PEND_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.cur_qlen <= QLEN_MIN;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign ctrl_location_select = s_q.sel;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence qspec_written_s;
    s_q.st == ST_WR_QLEN && xf.done;
  endsequence

  sequence queue_taken_s;
    s_q.ptr == '0 && s_q.cur_qstart == $past(s_q.qstart);
  endsequence

  AST_SEL_HOLD: assert property (
    !action_request_strobe_n |-> $stable(ctrl_location_select))
    else $error("select pins moved during strobe");

  AST_ONE_INIT: assert property (
    s_q.pstart |-> init_ok(s_q.act))
    else $error("several initialise bits issued");

  AST_LOOP_OK: assert property (
    s_q.pstart |-> loop_ok(s_q.act) && pcm_ok(s_q.act))
    else $error("disallowed loop or format issued");

  AST_QLEN_OK: assert property (
    s_q.pstart && s_q.act[ACT_NEW_QUEUE] |->
      s_q.cur_qlen >= QLEN_MIN && s_q.cur_qlen <= QLEN_MAX)
    else $error("queue length out of range");

  AST_NO_OVERLAP: assert property (
    s_q.pstart |-> !$past(s_q.outstanding) && !strobe_busy)
    else $error("request issued over an open one");

  AST_WRAP: assert property (
    s_q.ptr < s_q.cur_qlen)
    else $error("queue pointer beyond queue end");

  AST_ORDER: assert property (
    s_q.pstart |-> $past(s_q.st == ST_WR_ACT || s_q.st == ST_WR_QLEN))
    else $error("strobe before action word written");

  AST_NEW_QUEUE: assert property (
    qspec_written_s |=> queue_taken_s)
    else $error("new queue not taken over");

  AST_LOC_ADDR: assert property (
    s_q.xs && s_q.st == ST_WR_LOC |->
      s_q.xaddr == ctrl_location(s_q.sel))
    else $error("control start location wrong");

  AST_CS_LAYOUT: assert property (
    s_q.xs && s_q.st == ST_WR_QLEN |->
      s_q.xaddr == s_q.cfg_base + CS_QLEN_OFS)
    else $error("queue length word misplaced");
endmodule

//--- sim/dev_model.sv
/*
  Device and shared memory model behind the controller.
  Assumes one clock; mem_req is held until mem_ack.
*/
`timescale 1ns/10ps
module dev_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic kick,
  input wire logic [31:0] kick_word,
  input wire logic [4:0] ctrl_location_select,
  input wire logic action_request_strobe_n,
  output logic dev_irq,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  // ==========================================
  // Memory, queue state and action service.
  logic [31:0] mem [logic [31:0]];
  logic [31:0] cs, act, qs, ql, ptr;
  logic strb_q, misalign;
  int acts, wait_n;
  function automatic logic [31:0] loc(input logic [4:0] s);
    return {{10{s[4]}}, {6{s[3]}}, {12{s[2]}}, s[1], s[0], 2'h0};
  endfunction
  task automatic post(input logic [31:0] w);
    mem[qs + 4 * ptr] = w;
    ptr = (ptr + 1 == ql) ? 32'h0 : ptr + 1;
    dev_irq <= 1'b1;
  endtask
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {mem_ack, dev_irq, misalign} <= 3'h0;
      strb_q <= 1'b1;
      acts = 0;
      wait_n = 0;
    end else begin
      {mem_ack, dev_irq} <= 2'h0;
      strb_q <= action_request_strobe_n;
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_addr[1:0] != 2'h0) misalign <= 1'b1;
      if (mem_req && !mem_ack && wait_n++ >= (slow ? 5 : 0)) begin
        wait_n = 0;
        mem_ack <= 1'b1;
        if (mem_we) mem[mem_addr] = mem_wdata;
        else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
      end
      if (strb_q && !action_request_strobe_n) begin
        cs = mem[loc(ctrl_location_select)];
        act = mem[cs];
        acts++;
        if (act[2]) begin
          qs = mem[cs + 4];
          ql = mem[cs + 8] & 32'h1fff;
          ptr = 32'h0;
        end
        // Channel 31 stands for a configuration that cannot be done.
        if (!act[7] && act[12:8] == 5'h1f) post(32'h8000_4000);
        else if (!act[7]) post(32'h8000_8000);
      end else if (kick) post(kick_word);
    end
  end
endmodule

//--- sim/action_request_config_fetch_tb_top.sv
/*
  Bench for the action request controller with a device model.
  Assumes the package, interface and design files come first.
*/
`timescale 1ns/10ps
module action_request_config_fetch_tb_top;
  import arcf_pkg::*;
  // ==========================================
  // Signals, instances, clock and timeout.
  logic core_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, dev_irq, mem_req;
  logic action_request_strobe_n, mem_we, mem_ack, slow, kick;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [4:0] ctrl_location_select;
  logic [31:0] wb_dat_i, wb_dat_o, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] kick_word, rd, w;
  int bad_count, samples_checked, cycles, n;
  logic [2:0] pcms [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [2:0] loops [5] = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h6};
  logic [15:0] inits [5] = '{16'h0, 16'h8300, 16'h4500, 16'h40, 16'h80};
  logic [4:0] sels [5] = '{5'h0, 5'ha, 5'h15, 5'h1f, 5'h3};
  logic [31:0] bads [4] = '{32'hc000, 32'h38, 32'h20, 32'h2000_0000};
  action_request_config_fetch action_request_config_fetch_i (.*);
  dev_model dev_model_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 40000) begin
      bad_count++;
      complete_run();
    end
  end
  // ==========================================
  // Bus access, comparison and action tasks.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int t;
    t = 0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_i} <= {2'h3, we, a, d};
    @(posedge core_clk);
    while (wb_ack !== 1'b1 && t++ < 40) @(posedge core_clk);
    rd = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'h0;
    @(posedge core_clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic run_act(input logic [4:0] s, input logic [31:0] a,
                         input logic ok);
    int n0, t;
    logic fl;
    n0 = dev_model_i.acts;
    t = 0;
    fl = a[12:8] == 5'h1f;
    wb(1'b1, REG_SELECT, {27'h0, s});
    chk("select pins", {27'h0, s}, {27'h0, ctrl_location_select});
    wb(1'b1, REG_ACTION, a);
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("refused", 32'h1, {31'h0, rd[ST_REFUSED_BIT]});
    chk("mfl unset", {31'h0, a[28:16] == 13'h0},
        {31'h0, rd[ST_MFL_UNSET_BIT]});
    while (ok && rd[2:0] !== (fl ? 3'h4 : 3'h2) && t++ < 200)
      wb(1'b0, REG_STATUS, 32'h0);
    if (ok) chk("outcome", fl ? 32'h4 : 32'h2, {29'h0, rd[2:0]});
    chk("served", n0 + ok, dev_model_i.acts);
    if (ok) chk("location", 32'h100,
                dev_model_i.mem[dev_model_i.loc(s)]);
    wb(1'b0, REG_LAST_IRQ, 32'h0);
    if (ok && !a[7]) chk("ack word", fl ? 32'h8000_4000 : 32'h8000_8000,
                         rd);
    wb(1'b1, REG_STATUS, 32'he);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence.
  initial begin
    reset = 1'b1;
    {wb_cyc, wb_stb, wb_we, slow, kick} = 5'h0;
    {wb_adr, wb_sel, wb_dat_i, kick_word} = {8'h0, 4'hf, 64'h0};
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    wb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, REG_CFG_BASE, 32'h100);
    wb(1'b1, REG_QSTART, 32'h2000);
    wb(1'b1, REG_QLEN, 32'hf);
    run_act(5'h15, 32'h4, 1'b0);
    wb(1'b1, REG_QLEN, 32'h10);
    run_act(5'h15, 32'h4, 1'b1);
    chk("qlen word", 32'h10, dev_model_i.mem[32'h108]);
    for (int i = 0; i < 5; i++) begin
      slow <= i[0];
      w = {pcms[i], 13'h40, inits[i] | {10'h0, loops[i], 3'h0}};
      run_act(sels[i], w, 1'b1);
    end
    run_act(5'h2, 32'h1f00, 1'b1);
    for (int i = 0; i < 4; i++) run_act(5'h1, bads[i], 1'b0);
    for (int k = 0; k < 20; k++) begin
      kick_word <= 32'h8000_0000 | k;
      kick <= 1'b1;
      @(posedge core_clk);
      kick <= 1'b0;
      n = 0;
      do wb(1'b0, REG_LAST_IRQ, 32'h0);
      while (rd !== kick_word && n++ < 20);
      chk("queue word", kick_word, rd);
    end
    chk("aligned", 32'h0, {31'h0, dev_model_i.misalign});
    complete_run();
  end
endmodule
